// >>> qdlc_fifo.sv
/*
 qdlc_fifo: flip-flop fifo with valid/ready on both sides.
 assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ns
module qdlc_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 16
) (
	input  wire logic             core_clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wr_r;
	logic [AW-1:0]    rd_r;
	logic [AW:0]      cnt_r;
	logic             push;
	logic             pop;

	assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
	assign out_valid = (cnt_r != '0);
	assign out_data  = mem_r[rd_r];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			wr_r  <= '0;
			rd_r  <= '0;
			cnt_r <= '0;
		end else begin
			if (push) begin
				mem_r[wr_r] <= in_data;
				wr_r        <= wr_r + 1'b1;
			end
			if (pop)
				rd_r <= rd_r + 1'b1;
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// >>> qdlc_host.sv
/*
 qdlc_host: host side of the four-wire link, frame sender with readback.
 assumes the bench calls send between frames; the link clock idles high.
*/
`timescale 1ns/1ns
module qdlc_host (
	output logic      serial_clk,
	output logic      frame_n,
	output logic      serial_in,
	input  wire logic serial_out
);
	logic [23:0] rx_word;

	initial begin
		serial_clk = 1'b1;
		frame_n    = 1'b1;
		serial_in  = 1'b0;
		rx_word    = 24'h000000;
	end

	// ----------------------------------------
	// one frame, 48 ns link clock, still outside frames
	// ----------------------------------------
	task automatic send(input logic [23:0] w, input int n);
		frame_n = 1'b0;
		#24;
		for (int i = n - 1; i >= 0; i--) begin
			serial_in = w[i];
			#24 serial_clk = 1'b0;
			rx_word = {rx_word[22:0], serial_out};
			#24 serial_clk = 1'b1;
		end
		#24 frame_n = 1'b1;
		serial_in = ~serial_in;
		// frame select stays high over several core clocks between frames
		#250;
	endtask
endmodule

// >>> qdlc_pkg.sv
/*
 quad dac load and clear control: shared constants.
 assumes a 20 MHz core clock and a host-driven serial clock.
*/
package qdlc_pkg;
	localparam int          QDLC_CHANNELS   = 4;
	localparam int          QDLC_CODE_W     = 16;
	localparam int          QDLC_WORD_W     = 24;
	localparam int          QDLC_ADDR_LSB   = 16;
	localparam int          QDLC_FIFO_DEPTH = 16;
	localparam logic [4:0]  QDLC_BITS_FULL  = 5'h18;
	localparam logic [15:0] QDLC_CODE_RESET = 16'h0000;
	localparam logic [15:0] QDLC_CODE_ZERO  = 16'h0000;
	localparam logic [15:0] QDLC_CODE_MID   = 16'h8000;
	localparam logic [15:0] QDLC_CODE_TC_ZERO = 16'h8000;
	localparam logic [15:0] QDLC_CODE_TC_MID  = 16'h0000;
endpackage

// >>> qdlc_top.sv
/*
 qdlc_top: serial word capture, input and dac registers, load strobe and clear.
 assumes the host drives frame select, serial clock, data, load strobe and
 clear; the serial clock is a second domain that may stop between frames.
*/
`timescale 1ns/1ns
// Operation
// - strobe low: frame end updates addressed channel
// - strobe high: only input register updates
// - strobe falling edge loads all channels together
// - clear forces dac registers to zero/mid
// - shift register contents leave on serial_out
// - serial_out changes on rising serial clock
// - shift on falling clock, latch at frame end
// - one 24-bit word per frame
// - reset loads all dac registers with zero
module qdlc_top
	import qdlc_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        serial_clk,
	input  wire logic        frame_n,
	input  wire logic        serial_in,
	output logic             serial_out,
	input  wire logic        load_strobe_n,
	input  wire logic        async_zero_n,
	input  wire logic        clear_to_mid,
	input  wire logic        coding_select,
	output logic [15:0]      dac_code_a,
	output logic [15:0]      dac_code_b,
	output logic [15:0]      dac_code_c,
	output logic [15:0]      dac_code_d,
	output logic             frame_error
);
	// ----------------------------------------------------------------
	// link domain: shift on falling edge, drive out on rising edge
	// ----------------------------------------------------------------
	logic [23:0] shift_r;
	logic [4:0]  bits_r;
	logic        sout_r;

	// known contents before the first frame, so readback shows no unknowns
	always_ff @(negedge serial_clk or posedge rst) begin
		if (rst)
			shift_r <= '0;
		else if (!frame_n)
			shift_r <= {shift_r[22:0], serial_in};
	end

	// count held at zero between frames; saturates so long frames fail
	always_ff @(negedge serial_clk or posedge frame_n) begin
		if (frame_n)
			bits_r <= '0;
		else
			bits_r <= (&bits_r) ? bits_r : bits_r + 5'h01;
	end

	always_ff @(posedge serial_clk) begin
		sout_r <= shift_r[23];
	end
	assign serial_out = sout_r;

	// ----------------------------------------------------------------
	// frame end capture: word held stable while frame_n is high
	// ----------------------------------------------------------------
	logic [23:0] word_hold_r;
	logic [4:0]  cnt_hold_r;
	logic        frame_tog_r;

	always_ff @(posedge frame_n) begin
		word_hold_r <= shift_r;
		cnt_hold_r  <= bits_r;
	end

	// toggle starts known, so the core side sees no false frame after reset
	always_ff @(posedge frame_n or posedge rst) begin
		if (rst)
			frame_tog_r <= 1'b0;
		else
			frame_tog_r <= ~frame_tog_r;
	end

	// ----------------------------------------------------------------
	// core domain state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [2:0]                        tog_sync;
		logic [2:0]                        ld_sync;
		logic [1:0]                        clr_sync;
		logic [3:0]                        cfg_sync;
		logic                              pend_valid;
		logic [23:0]                       pend_word;
		logic                              pend_ok;
		logic                              frame_err;
		logic [QDLC_CHANNELS-1:0][15:0]    inreg;
		logic [QDLC_CHANNELS-1:0][15:0]    dacreg;
	} qdlc_state_t;

	qdlc_state_t st_r;
	qdlc_state_t st_nxt;

	logic [23:0] fifo_out_data;
	logic        fifo_out_valid;
	logic        fifo_out_ready;
	logic        fifo_in_ready;
	logic        frame_evt;
	logic        ld_low;
	logic        ld_fall;
	logic        clr_on;
	logic [15:0] clr_code;

	assign frame_evt = st_r.tog_sync[2] ^ st_r.tog_sync[1];
	assign ld_low    = ~st_r.ld_sync[1];
	assign ld_fall   = st_r.ld_sync[2] & ~st_r.ld_sync[1];
	assign clr_on    = ~st_r.clr_sync[1];

	// clear code honours the coding pin for bipolar twos complement
	always_comb begin
		if (st_r.cfg_sync[3])
			clr_code = st_r.cfg_sync[2] ? QDLC_CODE_MID : QDLC_CODE_TC_MID;
		else
			clr_code = st_r.cfg_sync[2] ? QDLC_CODE_ZERO : QDLC_CODE_TC_ZERO;
	end

	// ----------------------------------------------------------------
	// word fifo between frame capture and register update
	// ----------------------------------------------------------------
	qdlc_fifo #(
		.WIDTH (QDLC_WORD_W),
		.DEPTH (QDLC_FIFO_DEPTH)
	) u_fifo (
		.core_clk  (core_clk),
		.rst       (rst),
		.in_data   (st_r.pend_word),
		.in_valid  (st_r.pend_valid),
		.in_ready  (fifo_in_ready),
		.out_data  (fifo_out_data),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready)
	);
	// words wait in the fifo while a clear is held
	assign fifo_out_ready = ~clr_on;

	always_comb begin
		int unsigned ch;
		ch = 0;
		st_nxt = st_r;
		st_nxt.tog_sync = {st_r.tog_sync[1:0], frame_tog_r};
		st_nxt.ld_sync  = {st_r.ld_sync[1:0], load_strobe_n};
		st_nxt.clr_sync = {st_r.clr_sync[0], async_zero_n};
		st_nxt.cfg_sync = {st_r.cfg_sync[1:0], clear_to_mid, coding_select};
		if (st_r.pend_valid && fifo_in_ready)
			st_nxt.pend_valid = 1'b0;
		if (frame_evt) begin
			if (cnt_hold_r == QDLC_BITS_FULL) begin
				st_nxt.pend_valid = 1'b1;
				st_nxt.pend_word  = word_hold_r;
			end else begin
				st_nxt.frame_err = 1'b1;
			end
		end
		if (fifo_out_valid && fifo_out_ready) begin
			ch = int'(fifo_out_data[17:16]);
			st_nxt.inreg[ch] = fifo_out_data[15:0];
			if (ld_low)
				st_nxt.dacreg[ch] = fifo_out_data[15:0];
		end
		if (ld_fall)
			st_nxt.dacreg = st_nxt.inreg;
		if (clr_on)
			for (int i = 0; i < QDLC_CHANNELS; i++)
				st_nxt.dacreg[i] = clr_code;
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			st_r          <= '0;
			st_r.clr_sync <= 2'h3;
			for (int i = 0; i < QDLC_CHANNELS; i++) begin
				st_r.inreg[i]  <= QDLC_CODE_RESET;
				st_r.dacreg[i] <= QDLC_CODE_RESET;
			end
		end else begin
			st_r <= st_nxt;
		end
	end

	assign dac_code_a  = st_r.dacreg[0];
	assign dac_code_b  = st_r.dacreg[1];
	assign dac_code_c  = st_r.dacreg[2];
	assign dac_code_d  = st_r.dacreg[3];
	assign frame_error = st_r.frame_err;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence s_ld_fall;
		$fell(st_r.ld_sync[1]);
	endsequence

	sequence s_full_frame;
		frame_evt && cnt_hold_r == QDLC_BITS_FULL;
	endsequence

	sequence s_short_frame;
		frame_evt && cnt_hold_r != QDLC_BITS_FULL;
	endsequence

	sequence s_pend_taken;
		st_r.pend_valid && fifo_in_ready;
	endsequence

	a_reset_zero_dac: assert property (@(posedge core_clk)
		$fell(rst) |-> dac_code_a == QDLC_CODE_RESET && dac_code_d == QDLC_CODE_RESET)
		else $error("dac not zero after reset");

	a_strobe_load_all: assert property (@(posedge core_clk) disable iff (rst)
		s_ld_fall ##0 !clr_on |=> st_r.dacreg == st_r.inreg)
		else $error("strobe fall did not load all channels");

	a_clear_forces_code: assert property (@(posedge core_clk) disable iff (rst)
		clr_on |=> dac_code_a == $past(clr_code) && dac_code_b == $past(clr_code))
		else $error("clear did not force code");

	a_hold_when_high: assert property (@(posedge core_clk) disable iff (rst)
		!ld_low && !ld_fall && !clr_on |=> $stable(st_r.dacreg))
		else $error("dac changed while strobe high");

	a_direct_update: assert property (@(posedge core_clk) disable iff (rst)
		fifo_out_valid && fifo_out_ready && ld_low && !ld_fall
		|=> st_r.dacreg[$past(fifo_out_data[17:16])] == $past(fifo_out_data[15:0]))
		else $error("addressed channel not updated");

	a_input_reg_write: assert property (@(posedge core_clk) disable iff (rst)
		fifo_out_valid && fifo_out_ready
		|=> st_r.inreg[$past(fifo_out_data[17:16])] == $past(fifo_out_data[15:0]))
		else $error("input register not written");

	a_short_frame_err: assert property (@(posedge core_clk) disable iff (rst)
		frame_evt && cnt_hold_r != QDLC_BITS_FULL |=> frame_error && !st_r.pend_valid)
		else $error("short frame accepted");

	a_full_frame_push: assert property (@(posedge core_clk) disable iff (rst)
		frame_evt && cnt_hold_r == QDLC_BITS_FULL |=> st_r.pend_valid
		&& st_r.pend_word == $past(word_hold_r))
		else $error("frame word not captured");

	a_serial_out_msb: assert property (@(posedge serial_clk)
		1'b1 |=> serial_out == $past(shift_r[23]))
		else $error("serial out not msb");

	a_idle_dac_hold: assert property (@(posedge core_clk) disable iff (rst)
		!(fifo_out_valid && fifo_out_ready) && !ld_fall && !clr_on
		|=> $stable(st_r.dacreg))
		else $error("dac changed with no source");

	a_high_input_only: assert property (@(posedge core_clk) disable iff (rst)
		fifo_out_valid && fifo_out_ready && !ld_low && !ld_fall
		|=> $stable(st_r.dacreg)
		&& st_r.inreg[$past(fifo_out_data[17:16])] == $past(fifo_out_data[15:0]))
		else $error("strobe high write reached dac");

	a_error_sticky: assert property (@(posedge core_clk) disable iff (rst)
		frame_error |=> frame_error)
		else $error("frame error cleared without reset");

	a_reset_err_low: assert property (@(posedge core_clk)
		$fell(rst) |-> !frame_error && dac_code_b == QDLC_CODE_RESET
		&& dac_code_c == QDLC_CODE_RESET)
		else $error("state not clean after reset");

	a_clear_blocks: assert property (@(posedge core_clk) disable iff (rst)
		clr_on |-> !fifo_out_ready)
		else $error("fifo drained during clear");

	a_clear_mid_code: assert property (@(posedge core_clk) disable iff (rst)
		clr_on && st_r.cfg_sync[3] && st_r.cfg_sync[2]
		|=> dac_code_c == QDLC_CODE_MID && dac_code_d == QDLC_CODE_MID)
		else $error("midscale clear code wrong");

	a_clear_zero_code: assert property (@(posedge core_clk) disable iff (rst)
		clr_on && !st_r.cfg_sync[3] && st_r.cfg_sync[2]
		|=> dac_code_a == QDLC_CODE_ZERO && dac_code_b == QDLC_CODE_ZERO)
		else $error("zero scale clear code wrong");

	a_clear_over_strobe: assert property (@(posedge core_clk) disable iff (rst)
		s_ld_fall ##0 clr_on |=> dac_code_a == $past(clr_code))
		else $error("strobe load beat clear");

	a_pend_handoff: assert property (@(posedge core_clk) disable iff (rst)
		s_pend_taken ##0 !frame_evt |=> !st_r.pend_valid)
		else $error("pending word not handed to fifo");

	a_frame_to_fifo: assert property (@(posedge core_clk) disable iff (rst)
		s_full_frame ##1 s_pend_taken |=> fifo_out_valid)
		else $error("full frame never reached fifo");

	a_short_no_push: assert property (@(posedge core_clk) disable iff (rst)
		s_short_frame ##0 !st_r.pend_valid |=> !st_r.pend_valid)
		else $error("short frame queued");
endmodule

// >>> tb_top.sv
/*
 tb_top: self-checking bench for qdlc_top with the host model.
 assumes qdlc_pkg constants; inputs change at the core clock falling edge.
*/
`timescale 1ns/1ns
module tb_top
	import qdlc_pkg::*;
;
	typedef struct packed {logic [23:0] w; logic [15:0] e;} qdlc_row_t;
	logic        core_clk, rst, load_strobe_n, async_zero_n, clear_to_mid, coding_select;
	logic        serial_clk, frame_n, serial_in, serial_out, frame_error;
	logic [15:0] code [4];
	logic [15:0] model [4];
	logic [15:0] clr;
	int          fails, total_checks, cyc;
	qdlc_row_t   rows [5] = '{'{24'h00_1234, 16'h1234}, '{24'h01_ffff, 16'hffff},
		'{24'h02_8001, 16'h8001}, '{24'h03_0001, 16'h0001}, '{24'hfc_a5a5, 16'ha5a5}};

	qdlc_host host (.serial_clk(serial_clk), .frame_n(frame_n), .serial_in(serial_in),
		.serial_out(serial_out));
	qdlc_top dut (.core_clk(core_clk), .rst(rst), .serial_clk(serial_clk),
		.frame_n(frame_n), .serial_in(serial_in), .serial_out(serial_out),
		.load_strobe_n(load_strobe_n), .async_zero_n(async_zero_n),
		.clear_to_mid(clear_to_mid), .coding_select(coding_select),
		.dac_code_a(code[0]), .dac_code_b(code[1]), .dac_code_c(code[2]),
		.dac_code_d(code[3]), .frame_error(frame_error));

	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(negedge core_clk);
	endtask

	task automatic chk_all();
		for (int c = 0; c < 4; c++) chk(code[c], model[c]);
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			fails++;
			report_and_stop();
		end
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{rst, load_strobe_n, async_zero_n, clear_to_mid, coding_select} = 5'h15;
		{fails, total_checks, cyc} = '0;
		model = '{4{QDLC_CODE_RESET}};
		idle(16);
		rst = 1'b0;
		idle(2);
		chk_all();
		chk(frame_error, 1'b0);
		$display("reset test done");
		foreach (rows[i]) begin
			host.send(rows[i].w, 24);
			idle(12);
			model[rows[i].w[17:16]] = rows[i].e;
			chk_all();
			if (i > 0) chk(host.rx_word, rows[i - 1].w);
		end
		$display("row test done");
		load_strobe_n = 1'b1;
		idle(4);
		host.send(24'h00_5a5a, 24);
		host.send(24'h02_c3c3, 24);
		idle(12);
		chk_all();
		chk(host.rx_word, 24'h00_5a5a);
		{model[0], model[2]} = 32'h5a5a_c3c3;
		load_strobe_n = 1'b0;
		idle(6);
		chk_all();
		$display("strobe test done");
		host.send(24'h01_1111, 23);
		idle(12);
		chk(frame_error, 1'b1);
		chk_all();
		host.send(24'h01_2222, 24);
		idle(12);
		model[1] = 16'h2222;
		chk_all();
		$display("frame test done");
		for (int k = 0; k < 4; k++) begin
			{clear_to_mid, coding_select} = 2'(k);
			async_zero_n = 1'b0;
			idle(8);
			clr = clear_to_mid ? (coding_select ? QDLC_CODE_MID : QDLC_CODE_TC_MID)
				: (coding_select ? QDLC_CODE_ZERO : QDLC_CODE_TC_ZERO);
			model = '{4{clr}};
			chk_all();
			if (k < 3) async_zero_n = 1'b1;
			idle(4);
		end
		load_strobe_n = 1'b1;
		idle(4);
		load_strobe_n = 1'b0;
		idle(6);
		chk(code[0], clr);
		host.send(24'h03_7777, 24);
		idle(12);
		chk(code[3], clr);
		async_zero_n = 1'b1;
		idle(12);
		chk(code[3], 16'h7777);
		$display("clear test done");
		rst = 1'b1;
		idle(2);
		rst = 1'b0;
		idle(2);
		model = '{4{QDLC_CODE_RESET}};
		chk_all();
		chk(frame_error, 1'b0);
		$display("second reset test done");
		report_and_stop();
	end
endmodule
